/* File: verilog/css_defs.vh */
// Constants for the clock start-up and default clock-source block.
// Assumes inclusion by bare name from the design files that need it.
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// ------------------------------------------------------------------
// Register byte offsets on the APB slave
// ------------------------------------------------------------------
`define CSS_ADDR_CLKSEL   12'h000
`define CSS_ADDR_CAL      12'h004
`define CSS_ADDR_DIS0     12'h008
`define CSS_ADDR_DIS1     12'h00C
`define CSS_ADDR_SWITCH   12'h010
`define CSS_ADDR_STATUS   12'h014

// ------------------------------------------------------------------
// Field positions of the clock selection register
// ------------------------------------------------------------------
`define CSS_SRC_MSB       3
`define CSS_SRC_LSB       0
`define CSS_SUT_MSB       5
`define CSS_SUT_LSB       4
`define CSS_DIV8_BIT      8

// ------------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------------
`define CSS_SRC_RC        4'h2
`define CSS_SUT_DEF       2'h2
`define CSS_CAL_RST       8'h00
`define CSS_DIS_RST       8'h00
`define CSS_MODE_IDLE     2'h0
`define CSS_MODE_ADCNR    2'h1
`define CSS_MODE_PDOWN    2'h2
`define CSS_MODE_PSAVE    2'h3

// ------------------------------------------------------------------
// Timing counts, in ticks of the counted oscillator
// ------------------------------------------------------------------
`define CSS_RST_SHORT     15'h0200
`define CSS_RST_LONG      15'h2000
`define CSS_OSC_SU0       15'h0006
`define CSS_OSC_SU1       15'h0400
`define CSS_OSC_SU2       15'h4000
`define CSS_OSC_SU3       15'h0100
`define CSS_CNT_W         15

`endif

/* File: verilog/css_tick_counter.v */
// Tick counter that reports when a target number of ticks has passed.
// Assumes the tick input is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps

module css_tick_counter #(
   parameter WIDTH = 15
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire             restart,
   input  wire             tick,
   input  wire [WIDTH-1:0] target,
   output reg              done_r
);

   reg [WIDTH-1:0] count_r;
   reg [WIDTH-1:0] count_nxt;
   reg             done_nxt;

   // ---------------------------------------------------------------
   // Counting
   // ---------------------------------------------------------------
   // Restart wins over a tick so that a new interval always starts at
   // zero, even if a tick arrives in the same cycle.
   always @* begin
      count_nxt = count_r;
      done_nxt  = done_r;
      if (restart) begin
         count_nxt = {WIDTH{1'b0}};
         done_nxt  = 1'b0;
      end else if (tick && !done_r) begin
         count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
         if (count_nxt == target) begin
            done_nxt = 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= {WIDTH{1'b0}};
         done_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         done_r  <= done_nxt;
      end
   end

endmodule // css_tick_counter

/* File: verilog/css_clock_startup.v */
// Clock start-up sequencer and default clock-source logic with an APB
// register file. Assumes oscillator ticks arrive as one-cycle pulses
// synchronous to pclk and that fuse levels are stable after reset.
`timescale 1ns/1ps
`include "css_defs.vh"

module css_clock_startup #(
   parameter [14:0] RST_LONG_CYCLES = `CSS_RST_LONG,
   parameter [14:0] OSC_LONG_CYCLES = `CSS_OSC_SU2
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [3:0]  clock_select_fuses,
   input  wire [1:0]  startup_time_fuses,
   input  wire        divide_by_eight_fuse,
   input  wire        debug_enable_fuse,
   input  wire [7:0]  factory_cal_byte,
   input  wire        wdt_osc_tick,
   input  wire        src_osc_tick,
   input  wire        wdt_enable,
   input  wire        sleep_active,
   input  wire [1:0]  sleep_mode,
   input  wire [15:0] wake_pin_mask,
   output reg         cpu_hold,
   output reg  [3:0]  clock_source,
   output reg         sys_div8,
   output reg  [7:0]  rc_cal,
   output reg         rc_osc_en,
   output reg         ext_osc_en,
   output reg         wdt_osc_en,
   output reg  [15:0] in_buf_dis
);

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   // LOAD lasts one cycle and catches the fuses; RSTTO and OSCSU hold
   // fetch; SLEEP remembers whether the sleep mode was a deep one.
   localparam [2:0] ST_LOAD  = 3'h0;
   localparam [2:0] ST_RSTTO = 3'h1;
   localparam [2:0] ST_OSCSU = 3'h2;
   localparam [2:0] ST_RUN   = 3'h3;
   localparam [2:0] ST_SLEEP = 3'h4;

   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [8:0]  clock_selection_register_r;
   reg [3:0]  active_src_r;
   reg [1:0]  active_sut_r;
   reg [7:0]  rc_calibration_register_r;
   reg [7:0]  input_disable_reg_zero_r;
   reg [7:0]  input_disable_reg_one_r;
   reg        deep_sleep_r;
   reg        deep_sleep_nxt;
   reg [3:0]  active_src_nxt;
   reg [1:0]  active_sut_nxt;
   reg [14:0] rst_target;
   reg [14:0] osc_target;
   reg        rst_restart;
   reg        osc_restart;
   reg [31:0] rd_data;
   reg        rd_err;
   wire       rst_done;
   wire       osc_done;
   wire       apb_setup;
   wire       apb_write;
   wire       sw_switch;
   wire [3:0] new_src;
   wire       src_off;

   // ---------------------------------------------------------------
   // Start-up counters
   // ---------------------------------------------------------------
   // The reset delay counts watchdog ticks whatever the system source
   // is, so it stays valid while the RC oscillator is still settling.
   // Each counter reports done from a flop, so the sequencer reacts one
   // clock after the last tick of an interval.
   css_tick_counter #(
      .WIDTH (`CSS_CNT_W)
   ) u_rst_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (rst_restart),
      .tick    (wdt_osc_tick),
      .target  (rst_target),
      .done_r  (rst_done)
   );

   css_tick_counter #(
      .WIDTH (`CSS_CNT_W)
   ) u_osc_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (osc_restart),
      .tick    (src_osc_tick),
      .target  (osc_target),
      .done_r  (osc_done)
   );

   // The reset delay only looks at the top bit of the start-up field,
   // so the factory setting selects the long delay. Source start-up
   // counts come from the same field, taken when the interval opens.
   always @* begin
      rst_target = active_sut_r[1] ? RST_LONG_CYCLES : `CSS_RST_SHORT;
      case (active_sut_r)
         2'h0:    osc_target = `CSS_OSC_SU0;
         2'h1:    osc_target = `CSS_OSC_SU1;
         2'h2:    osc_target = OSC_LONG_CYCLES;
         default: osc_target = `CSS_OSC_SU3;
      endcase
   end

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pready && pwrite;
   // A switch request is honoured only on a completed write access.
   assign sw_switch = apb_write && (paddr == `CSS_ADDR_SWITCH) && pwdata[0];
   assign new_src   = clock_selection_register_r[`CSS_SRC_MSB:`CSS_SRC_LSB];

   // Unused bits read as zero; an unmapped offset answers with an
   // error and zero data.
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (paddr)
         `CSS_ADDR_CLKSEL: rd_data[8:0] = clock_selection_register_r;
         `CSS_ADDR_CAL:    rd_data[7:0] = rc_calibration_register_r;
         `CSS_ADDR_DIS0:   rd_data[7:0] = input_disable_reg_zero_r;
         `CSS_ADDR_DIS1:   rd_data[7:0] = input_disable_reg_one_r;
         `CSS_ADDR_SWITCH: rd_data = 32'h0000_0000;
         `CSS_ADDR_STATUS: rd_data[11:0] = {deep_sleep_r, osc_done,
                                            rst_done, active_sut_r,
                                            active_src_r, state_r};
         default:          rd_err = 1'b1;
      endcase
   end

   // Wait state free: the answer is staged at the setup edge and
   // the access phase always completes at its first edge. Read data is
   // driven only while pready stands, so a stale word never lingers on
   // the bus after the access.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup && rd_err;
         if (apb_setup && !pwrite) begin
            prdata <= rd_data;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------
   // Fuse and calibration levels are caught in the first clocked cycle
   // after reset release, never inside the asynchronous reset branch.
   // Bits 7:6 of the selection register are reserved and read zero.
   // A bus write in the load cycle is lost; the fuse copy wins.
   // Software may retune the RC oscillator at any time after the load.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_selection_register_r <= {1'b1, 2'h0, `CSS_SUT_DEF,
                                        `CSS_SRC_RC};
         rc_calibration_register_r  <= `CSS_CAL_RST;
         input_disable_reg_zero_r   <= `CSS_DIS_RST;
         input_disable_reg_one_r    <= `CSS_DIS_RST;
      end else if (state_r == ST_LOAD) begin
         clock_selection_register_r <= {divide_by_eight_fuse, 2'h0,
                                        startup_time_fuses,
                                        clock_select_fuses};
         rc_calibration_register_r  <= factory_cal_byte;
      end else if (apb_write) begin
         case (paddr)
            `CSS_ADDR_CLKSEL: begin
               clock_selection_register_r <= {pwdata[`CSS_DIV8_BIT], 2'h0,
                  pwdata[`CSS_SUT_MSB:`CSS_SUT_LSB],
                  pwdata[`CSS_SRC_MSB:`CSS_SRC_LSB]};
            end
            `CSS_ADDR_CAL: begin
               rc_calibration_register_r <= pwdata[7:0];
            end
            `CSS_ADDR_DIS0: begin
               input_disable_reg_zero_r <= pwdata[7:0];
            end
            `CSS_ADDR_DIS1: begin
               input_disable_reg_one_r <= pwdata[7:0];
            end
            default: begin
               input_disable_reg_one_r <= input_disable_reg_one_r;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Start-up sequencer
   // ---------------------------------------------------------------
   always @* begin
      state_nxt      = state_r;
      active_src_nxt = active_src_r;
      active_sut_nxt = active_sut_r;
      deep_sleep_nxt = deep_sleep_r;
      rst_restart    = 1'b0;
      osc_restart    = 1'b0;
      case (state_r)
         ST_LOAD: begin
            // Fuses are read directly; the register copy lands on this edge.
            active_src_nxt = clock_select_fuses;
            active_sut_nxt = startup_time_fuses;
            rst_restart    = 1'b1;
            state_nxt      = ST_RSTTO;
         end
         ST_RSTTO: begin
            // The source interval opens only once the reset delay is over.
            if (rst_done) begin
               osc_restart = 1'b1;
               state_nxt   = ST_OSCSU;
            end
         end
         ST_OSCSU: begin
            if (osc_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // Sleep wins over a switch written in the same cycle.
            if (sleep_active) begin
               deep_sleep_nxt = (sleep_mode == `CSS_MODE_PDOWN) ||
                                (sleep_mode == `CSS_MODE_PSAVE);
               state_nxt      = ST_SLEEP;
            end else if (sw_switch) begin
               // A switch takes the source and start-up fields as they
               // stand in the selection register at that moment.
               active_src_nxt = new_src;
               active_sut_nxt =
                  clock_selection_register_r[`CSS_SUT_MSB:`CSS_SUT_LSB];
               osc_restart    = 1'b1;
               state_nxt      = ST_OSCSU;
            end
         end
         ST_SLEEP: begin
            // Only a deep sleep stopped the source, so only it is retimed.
            if (!sleep_active) begin
               deep_sleep_nxt = 1'b0;
               if (deep_sleep_r) begin
                  osc_restart = 1'b1;
                  state_nxt   = ST_OSCSU;
               end else begin
                  state_nxt = ST_RUN;
               end
            end
         end
         default: begin
            // An unused code falls back to a full reload of the fuses.
            state_nxt = ST_LOAD;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= ST_LOAD;
         active_src_r <= `CSS_SRC_RC;
         active_sut_r <= `CSS_SUT_DEF;
         deep_sleep_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         active_src_r <= active_src_nxt;
         active_sut_r <= active_sut_nxt;
         deep_sleep_r <= deep_sleep_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Clock and buffer controls
   // ---------------------------------------------------------------
   // In deep sleep the source stops, unless debug must keep it alive.
   // The price of debug is that deep sleep current is not reached.
   assign src_off = deep_sleep_nxt && (state_nxt == ST_SLEEP) &&
                    !debug_enable_fuse;

   // Hold, source, enable and buffer outputs are registered from the next-state terms so that each
   // changes on the same edge as the sequencer state it reflects.
   // The watchdog oscillator runs through the whole reset delay even
   // when the watchdog itself is off, because the delay counts on it.
   // Deep sleep spares the wake-up pin buffers so a wake event is still seen, but their software disable bits still apply.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_hold     <= 1'b1;
         clock_source <= `CSS_SRC_RC;
         sys_div8     <= 1'b1;
         rc_cal       <= `CSS_CAL_RST;
         rc_osc_en    <= 1'b1;
         ext_osc_en   <= 1'b0;
         wdt_osc_en   <= 1'b1;
         in_buf_dis   <= 16'h0000;
      end else begin
         cpu_hold     <= (state_nxt != ST_RUN);
         clock_source <= active_src_nxt;
         sys_div8     <= (state_r == ST_LOAD) ? divide_by_eight_fuse :
                         clock_selection_register_r[`CSS_DIV8_BIT];
         rc_cal       <= rc_calibration_register_r;
         rc_osc_en    <= (active_src_nxt == `CSS_SRC_RC) && !src_off;
         ext_osc_en   <= (active_src_nxt != `CSS_SRC_RC) && !src_off;
         wdt_osc_en   <= wdt_enable || (state_nxt == ST_LOAD) ||
                         (state_nxt == ST_RSTTO);
         in_buf_dis   <= {input_disable_reg_one_r,
                          input_disable_reg_zero_r} |
                         ((deep_sleep_nxt && state_nxt == ST_SLEEP) ?
                          ~wake_pin_mask : 16'h0000);
      end
   end

endmodule // css_clock_startup

/* File: verif/css_clock_startup_properties.sv */
// Port checks for the clock start-up block, bound to its top module.
// Assumes the core is only put to sleep while it runs.
`timescale 1ns/1ps
module css_clock_startup_props (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        debug_enable_fuse,
   input logic        wdt_enable,
   input logic        sleep_active,
   input logic [1:0]  sleep_mode,
   input logic [15:0] wake_pin_mask,
   input logic        cpu_hold,
   input logic [3:0]  clock_source,
   input logic        rc_osc_en,
   input logic        ext_osc_en,
   input logic        wdt_osc_en,
   input logic [15:0] in_buf_dis
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_pready_one: assert property (pready |=> !pready)
      else $error("pready lasted more than one cycle");
   chk_pready_setup: assert property (psel && !penable |=> pready)
      else $error("no answer in the cycle after setup");
   chk_err_pair: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside an answer");
   chk_osc_select: assert property (
      !cpu_hold && !sleep_active |-> rc_osc_en == (clock_source == 4'h2)
      && ext_osc_en == (clock_source != 4'h2))
      else $error("oscillator enables disagree with the source");
   chk_wdt_run: assert property (wdt_enable |=> wdt_osc_en)
      else $error("watchdog oscillator stopped");
   chk_buf_deep: assert property (
      !cpu_hold && sleep_active && sleep_mode[1] ##1 sleep_active [*3]
      |-> (in_buf_dis | wake_pin_mask) == 16'hFFFF)
      else $error("input buffer left on in deep sleep");
   chk_clk_deep: assert property (
      !cpu_hold && sleep_active && sleep_mode[1] ##1 sleep_active [*3]
      |-> (rc_osc_en || ext_osc_en) == debug_enable_fuse)
      else $error("main clock state wrong in deep sleep");
   chk_hold_wake: assert property (
      sleep_active && sleep_mode[1] ##1 !sleep_active |=> cpu_hold [*2])
      else $error("fetch released before start-up on wake");
endmodule // css_clock_startup_props

bind css_clock_startup css_clock_startup_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .debug_enable_fuse(debug_enable_fuse), .wdt_enable(wdt_enable),
   .sleep_active(sleep_active), .sleep_mode(sleep_mode),
   .wake_pin_mask(wake_pin_mask), .cpu_hold(cpu_hold),
   .clock_source(clock_source), .rc_osc_en(rc_osc_en),
   .ext_osc_en(ext_osc_en), .wdt_osc_en(wdt_osc_en),
   .in_buf_dis(in_buf_dis));

/* File: verif/testbench.sv */
// Self-checking bench for the clock start-up block over APB.
// Assumes shortened long counts so the run stays brief.
`timescale 1ns/1ps
module testbench;
   localparam integer RST_N = 16;
   localparam integer OSC_N = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        div8_f, dbg_f, wdt_t, src_t, wdt_en, slp, cpu_hold;
   logic        sys_div8, rc_en, ext_en, wdt_en_o;
   logic [3:0]  src_f, clock_source;
   logic [1:0]  sut_f, sleep_mode;
   logic [7:0]  cal_f, rc_cal;
   logic [15:0] wake_mask, in_buf_dis;
   integer      bad_count, n_tests;

   css_clock_startup #(.RST_LONG_CYCLES(15'(RST_N)),
      .OSC_LONG_CYCLES(15'(OSC_N))) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .clock_select_fuses(src_f),
      .startup_time_fuses(sut_f), .divide_by_eight_fuse(div8_f),
      .debug_enable_fuse(dbg_f), .factory_cal_byte(cal_f),
      .wdt_osc_tick(wdt_t), .src_osc_tick(src_t), .wdt_enable(wdt_en),
      .sleep_active(slp), .sleep_mode(sleep_mode), .wake_pin_mask(wake_mask),
      .cpu_hold(cpu_hold), .clock_source(clock_source), .sys_div8(sys_div8),
      .rc_cal(rc_cal), .rc_osc_en(rc_en), .ext_osc_en(ext_en),
      .wdt_osc_en(wdt_en_o), .in_buf_dis(in_buf_dis));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic final_report;
      $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // The idle edge after each transfer lets register outputs settle.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      integer i;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i = i + 1;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic tick(input logic wdt, input integer n);
      repeat (n) begin
         if (wdt)
            wdt_t <= 1'b1;
         else
            src_t <= 1'b1;
         @(posedge pclk);
         wdt_t <= 1'b0;
         src_t <= 1'b0;
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic do_reset(input logic [3:0] s, input logic [1:0] u,
                           input logic dv, input logic db,
                           input logic [7:0] c);
      src_f   <= s;
      sut_f   <= u;
      div8_f  <= dv;
      dbg_f   <= db;
      cal_f   <= c;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'({cpu_hold, rc_en, ext_en, wdt_en_o, rc_cal, in_buf_dis}),
          32'hD000000);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'({clock_source, sys_div8, rc_cal}), 32'({s, dv, c}));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'({dv, 2'h0, u, s}));
   endtask

   task automatic startup(input integer nw, input integer ns);
      tick(1'b1, nw - 1);
      chk(32'(wdt_en_o), 32'h1);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd & 32'h600, 32'h0);
      tick(1'b1, 1);
      apb(1'b0, 12'h014, 32'h0);
      chk(rd & 32'h600, 32'h200);
      tick(1'b0, ns - 1);
      chk(32'(cpu_hold), 32'h1);
      tick(1'b0, 1);
      chk(32'(cpu_hold), 32'h0);
   endtask

   task automatic regs_test;
      apb(1'b1, 12'h004, 32'h3C);
      apb(1'b0, 12'h004, 32'h0);
      chk(32'({rd[7:0], rc_cal}), 32'h3C3C);
      apb(1'b1, 12'h008, 32'h81);
      apb(1'b1, 12'h00C, 32'h42);
      @(posedge pclk);
      chk(32'(in_buf_dis), 32'h4281);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask

   task automatic switch_test;
      apb(1'b1, 12'h000, 32'h33);
      apb(1'b1, 12'h010, 32'h1);
      chk(32'({cpu_hold, clock_source, sys_div8}), 32'h26);
      tick(1'b0, 255);
      chk(32'(cpu_hold), 32'h1);
      tick(1'b0, 1);
      chk(32'({cpu_hold, rc_en, ext_en}), 32'h1);
   endtask

   task automatic sleep_test;
      integer m;
      wdt_en    <= 1'b1;
      wake_mask <= 16'h0003;
      for (m = 0; m < 4; m = m + 1) begin
         sleep_mode <= m[1:0];
         @(posedge pclk);
         slp <= 1'b1;
         repeat (4) @(posedge pclk);
         chk(32'(in_buf_dis), m[1] ? 32'hFFFD : 32'h4281);
         chk(32'({ext_en, wdt_en_o}), m[1] ? 32'h1 : 32'h3);
         slp <= 1'b0;
         repeat (3) @(posedge pclk);
         if (m[1])
            tick(1'b0, 256);
         chk(32'({cpu_hold, in_buf_dis}), 32'h4281);
      end
   endtask

   initial begin
      #250000;
      bad_count = bad_count + 1;
      final_report;
   end

   initial begin
      bad_count  = 0;
      n_tests    = 0;
      presetn    = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      src_f      = 4'h2;
      sut_f      = 2'h2;
      div8_f     = 1'b1;
      dbg_f      = 1'b0;
      cal_f      = 8'hA5;
      wdt_t      = 1'b0;
      src_t      = 1'b0;
      wdt_en     = 1'b0;
      slp        = 1'b0;
      sleep_mode = 2'h0;
      wake_mask  = 16'h0000;
      @(posedge pclk);
      do_reset(4'h2, 2'h2, 1'b1, 1'b0, 8'hA5);
      startup(RST_N, OSC_N);
      regs_test;
      switch_test;
      sleep_test;
      do_reset(4'h2, 2'h1, 1'b0, 1'b1, 8'h11);
      startup(512, 1024);
      sleep_mode <= 2'h3;
      @(posedge pclk);
      slp <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'({rc_en, sys_div8, wdt_en_o}), 32'h5);
      final_report;
   end
endmodule // testbench
